// File: core/pci_cfg_pm_defines.svh
/*
 * offsets, field positions, reset values and timing counts for the
 * configuration-space register bank with its power-management block.
 * assumes the includer works at a 40 MHz core clock.
 */
`ifndef PCI_CFG_PM_DEFINES_SVH
`define PCI_CFG_PM_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CLASS_REVISION 8'h08
`define OFS_LATENCY_CACHE_LINE 8'h0C
`define OFS_CSR_BASE_ADDRESS 8'h10
`define OFS_SUBSYSTEM_IDENTITY 8'h2C
`define OFS_CAPABILITY_POINTER 8'h34
`define OFS_INTERRUPT_ROUTING 8'h3C
`define OFS_PM_CAPABILITY 8'h50
`define OFS_PM_CONTROL_STATUS 8'h54

// ****************************************
// fixed values and field positions
// ****************************************
`define CLASS_NETWORK 8'h02
`define SUBCLASS_ETHERNET 8'h00
`define CAP_PTR_PM 8'h50
`define CAP_PTR_NONE 8'h00
`define MAX_LAT_VALUE 8'h28
`define MIN_GNT_VALUE 8'h14
`define INT_PIN_INTA 8'h01
`define PM_CAP_ID 8'h01
`define PM_NEXT_PTR 8'h00
`define AUX_CURRENT_NONE 3'h0
`define BASE_ADDR_LSB 11
`define PM_STATUS_BIT 15
`define PM_ENABLE_BIT 8
`define PM_NO_SOFT_RST_BIT 3
`define PSTATE_D0 2'h0
`define PSTATE_D3HOT 2'h3
`define NEW_CAP_STATUS_BIT 20

// ****************************************
// timing
// ****************************************
`define EE_START_CYC 50
`define EE_LOAD_PCI_CYC 27400
`define PCI_REF_MHZ 33
`define CORE_MHZ 40
// least load time, rounded up to whole core cycles
`define EE_LOAD_CORE_CYC ((`EE_LOAD_PCI_CYC * `CORE_MHZ + `PCI_REF_MHZ - 1) / `PCI_REF_MHZ)

`endif

// File: core/pci_cfg_pm_pkg.sv
/*
 * types shared by the configuration-space bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pci_cfg_pm_pkg;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic write;
        logic [5:0] dword_idx;
        logic [3:0] byte_en_n;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic new_cap;
        logic wake_d3cold;
        logic wake_d2;
        logic wake_d1;
        logic state2_support;
        logic state1_support;
        logic special_init;
        logic wake_clock;
        logic [2:0] pm_version;
    } ee_cfg_t;

    typedef enum logic [1:0] {
        LD_WAIT = 2'b00,
        LD_BUSY = 2'b01,
        LD_DONE = 2'b10
    } load_state_t;

endpackage

// File: core/pci_config_space_pm.sv
/*
 * configuration-space register bank with power-management capability,
 * eeprom-loaded subsystem identity, latency timer and wake output.
 * assumes the bus target front end turns each configuration cycle into one
 * CFG_REQ pulse and that an eeprom loader on CORE_CLK presents its words.
 */
`timescale 1ns/100ps
`include "pci_cfg_pm_defines.svh"

module pci_config_space_pm
    import pci_cfg_pm_pkg::*;
#(
    parameter int EE_LOAD_CYCLES = `EE_LOAD_CORE_CYC,
    parameter bit NO_SOFT_RESET = 1'b0
) (
    input wire logic CORE_CLK, // core clock, 40 MHz
    input wire logic RESET_N, // hardware reset, async, low
    input wire logic POWER_UP_RESET_N, // power-up reset, async, low
    input wire logic CFG_REQ, // one-cycle configuration request
    input wire cfg_req_t CFG_CMD, // request fields, valid with CFG_REQ
    output logic CFG_DONE, // one-cycle normal completion
    output logic CFG_RETRY, // one-cycle retry termination
    output logic [31:0] CFG_RDATA, // read data, valid with CFG_DONE
    input wire logic [31:0] EE_SUBSYS, // eeprom identity word
    input wire ee_cfg_t EE_CFG, // eeprom capability bits
    input wire logic EE_VALID, // eeprom words valid
    input wire logic FRAME_OUT_N, // own master frame, low active
    input wire logic GNT_N, // bus grant pin, low active
    output logic LAT_TERMINATE, // begin master termination
    input wire logic PM_EVENT, // one-cycle power-management event
    output logic WAKE_OUT_N_O, // wake pin output value
    output logic WAKE_OUT_N_OE_N, // wake pin enable, low drives
    output logic NEW_CAP_FLAG, // new-capability status flag
    output logic [15:0] PM_CAP_MIRROR, // mirror of capabilities upper half
    output logic [31:0] CSR_BASE_ADDR, // control/status block base
    output logic [1:0] POWER_STATE, // current power state
    output logic LOAD_DONE, // eeprom load completed
    output logic SOFT_RESET_OUT // one-cycle internal reset request
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        load_state_t ld;
        logic [19:0] ld_cnt;
        logic [31:0] subsys;
        ee_cfg_t ee;
        logic [7:0] cache_line;
        logic [7:0] lat_timer;
        logic [20:0] base;
        logic [7:0] int_line;
        logic [1:0] pstate;
        logic [2:0] gnt_sync;
        logic frame_q;
        logic lat_run;
        logic [7:0] lat_cnt;
        logic lat_exp;
        logic done;
        logic retry;
        logic [31:0] rdata;
        logic soft_rst;
    } core_state_t;

    typedef struct packed {
        logic wake_status;
        logic wake_enable;
    } pm_keep_t;

    core_state_t cur;
    core_state_t next_cur;
    pm_keep_t keep;
    pm_keep_t next_keep;
    logic [31:0] pm_cap;
    logic [31:0] rd_word;
    logic [7:0] byte_addr;
    logic wr;
    logic rd;
    logic gnt_high;

    // ****************************************
    // decode and read view
    // ****************************************
    // register offset from dword index
    assign byte_addr = {CFG_CMD.dword_idx, 2'b00};
    assign wr = CFG_REQ & CFG_CMD.write;
    assign rd = CFG_REQ & ~CFG_CMD.write;
    // grant counts high once the two late stages are both high
    assign gnt_high = cur.gnt_sync[1] & cur.gnt_sync[2];

    // capability word built from eeprom bits
    assign pm_cap = {cur.ee.wake_d3cold, 1'b1, cur.ee.wake_d2, cur.ee.wake_d1,
                     1'b0, cur.ee.state2_support, cur.ee.state1_support,
                     `AUX_CURRENT_NONE,
                     cur.ee.special_init, 1'b0, cur.ee.wake_clock, cur.ee.pm_version,
                     `PM_NEXT_PTR, `PM_CAP_ID};

    // read mux, zero for anything not implemented
    always_comb begin
        case (byte_addr)
            `OFS_CLASS_REVISION: rd_word = {`CLASS_NETWORK, `SUBCLASS_ETHERNET, 16'h0010};
            `OFS_LATENCY_CACHE_LINE: rd_word = {16'h0000, cur.lat_timer, cur.cache_line};
            `OFS_CSR_BASE_ADDRESS: rd_word = {cur.base, 11'h000};
            `OFS_SUBSYSTEM_IDENTITY: rd_word = cur.subsys;
            `OFS_CAPABILITY_POINTER: rd_word = {24'h00_0000, cur.ee.new_cap ? `CAP_PTR_PM : `CAP_PTR_NONE};
            `OFS_INTERRUPT_ROUTING: rd_word = {`MAX_LAT_VALUE, `MIN_GNT_VALUE, `INT_PIN_INTA, cur.int_line};
            `OFS_PM_CAPABILITY: rd_word = pm_cap;
            `OFS_PM_CONTROL_STATUS: rd_word = {16'h0000, keep.wake_status, 6'h00, keep.wake_enable,
                                               4'h0, NO_SOFT_RESET, 1'b0, cur.pstate};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // next state of hardware-reset domain
    // ****************************************
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.retry = 1'b0;
        next_cur.soft_rst = 1'b0;
        next_cur.gnt_sync = {cur.gnt_sync[1:0], GNT_N};
        // eeprom load sequencing
        case (cur.ld)
            LD_WAIT: begin
                next_cur.ld_cnt = cur.ld_cnt + 20'd1;
                if (cur.ld_cnt == 20'(`EE_START_CYC - 1)) begin
                    next_cur.ld = LD_BUSY;
                    next_cur.ld_cnt = 20'd0;
                end
            end
            LD_BUSY: begin
                if (cur.ld_cnt != 20'(EE_LOAD_CYCLES)) begin
                    next_cur.ld_cnt = cur.ld_cnt + 20'd1;
                end else if (EE_VALID) begin
                    next_cur.ld = LD_DONE;
                    next_cur.subsys = EE_SUBSYS;
                    next_cur.ee = EE_CFG;
                end
            end
            LD_DONE: next_cur.ld = LD_DONE;
            default: next_cur.ld = LD_WAIT;
        endcase
        // latency counter on own master frame
        next_cur.frame_q = ~FRAME_OUT_N;
        if (FRAME_OUT_N) begin
            next_cur.lat_run = 1'b0;
            next_cur.lat_exp = 1'b0;
            next_cur.lat_cnt = 8'h00;
        end else if (!cur.frame_q) begin
            next_cur.lat_run = 1'b1;
            next_cur.lat_cnt = 8'h00;
            next_cur.lat_exp = (cur.lat_timer == 8'h00);
        end else if (cur.lat_run && !cur.lat_exp) begin
            next_cur.lat_cnt = cur.lat_cnt + 8'h01;
            next_cur.lat_exp = (cur.lat_cnt + 8'h01 >= cur.lat_timer);
        end
        // configuration access
        if (rd) begin
            if (byte_addr == `OFS_SUBSYSTEM_IDENTITY && cur.ld != LD_DONE) begin
                next_cur.retry = 1'b1;
            end else begin
                next_cur.done = 1'b1;
                next_cur.rdata = rd_word;
            end
        end
        if (wr) begin
            next_cur.done = 1'b1;
            case (byte_addr)
                `OFS_LATENCY_CACHE_LINE: begin
                    if (!CFG_CMD.byte_en_n[0]) next_cur.cache_line = CFG_CMD.wdata[7:0];
                    if (!CFG_CMD.byte_en_n[1]) next_cur.lat_timer = CFG_CMD.wdata[15:8];
                end
                `OFS_CSR_BASE_ADDRESS: begin
                    if (!CFG_CMD.byte_en_n[1]) next_cur.base[4:0] = CFG_CMD.wdata[15:11];
                    if (!CFG_CMD.byte_en_n[2]) next_cur.base[12:5] = CFG_CMD.wdata[23:16];
                    if (!CFG_CMD.byte_en_n[3]) next_cur.base[20:13] = CFG_CMD.wdata[31:24];
                end
                `OFS_INTERRUPT_ROUTING: begin
                    if (!CFG_CMD.byte_en_n[0]) next_cur.int_line = CFG_CMD.wdata[7:0];
                end
                `OFS_PM_CONTROL_STATUS: begin
                    if (!CFG_CMD.byte_en_n[0]) begin
                        next_cur.pstate = CFG_CMD.wdata[1:0];
                        // D3hot to D0 under software control
                        if (cur.pstate == `PSTATE_D3HOT && CFG_CMD.wdata[1:0] == `PSTATE_D0
                                && !NO_SOFT_RESET) begin
                            next_cur.soft_rst = 1'b1;
                        end
                    end
                end
                default: next_cur.done = 1'b1;
            endcase
        end
    end

    // ****************************************
    // next state of power-up domain
    // ****************************************
    always_comb begin
        next_keep = keep;
        if (wr && byte_addr == `OFS_PM_CONTROL_STATUS && !CFG_CMD.byte_en_n[1]) begin
            next_keep.wake_enable = CFG_CMD.wdata[`PM_ENABLE_BIT];
            if (CFG_CMD.wdata[`PM_STATUS_BIT]) next_keep.wake_status = 1'b0;
        end
        // a new event wins over a clear in the same cycle
        if (PM_EVENT) next_keep.wake_status = 1'b1;
    end

    // ****************************************
    // registers
    // ****************************************
    // configuration registers return to defaults on hardware reset
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cur <= '0;
            cur.gnt_sync <= 3'h7;
        end else begin
            cur <= next_cur;
        end
    end

    // wake context survives hardware and software reset
    always_ff @(posedge CORE_CLK or negedge POWER_UP_RESET_N) begin
        if (!POWER_UP_RESET_N) begin
            keep <= '0;
        end else begin
            keep <= next_keep;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign CFG_DONE = cur.done;
    assign CFG_RETRY = cur.retry;
    assign CFG_RDATA = cur.rdata;
    // expired count ends the transfer once grant is withdrawn
    assign LAT_TERMINATE = cur.lat_exp & ~FRAME_OUT_N & gnt_high;
    assign WAKE_OUT_N_O = 1'b0;
    assign WAKE_OUT_N_OE_N = ~(keep.wake_status & keep.wake_enable);
    assign NEW_CAP_FLAG = cur.ee.new_cap;
    assign PM_CAP_MIRROR = pm_cap[31:16];
    assign CSR_BASE_ADDR = {cur.base, 11'h000};
    assign POWER_STATE = cur.pstate;
    assign LOAD_DONE = (cur.ld == LD_DONE);
    assign SOFT_RESET_OUT = cur.soft_rst;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N || !POWER_UP_RESET_N);

    sequence s_read_req(logic [7:0] ofs);
        rd && byte_addr == ofs;
    endsequence

    sequence s_d3_to_d0;
        wr && byte_addr == `OFS_PM_CONTROL_STATUS && !CFG_CMD.byte_en_n[0]
            && cur.pstate == `PSTATE_D3HOT && CFG_CMD.wdata[1:0] == `PSTATE_D0;
    endsequence

    a_class_fixed: assert property (s_read_req(`OFS_CLASS_REVISION) |=> CFG_DONE
        && CFG_RDATA[31:16] == 16'h0200) else $error("class bytes wrong");
    a_retry_early: assert property (s_read_req(`OFS_SUBSYSTEM_IDENTITY) ##0 !LOAD_DONE
        |=> CFG_RETRY && !CFG_DONE) else $error("early identity read not retried");
    a_load_not_early: assert property ($rose(LOAD_DONE) |-> $past(cur.ld_cnt) == 20'(EE_LOAD_CYCLES))
        else $error("load finished too soon");
    a_base_low_zero: assert property (s_read_req(`OFS_CSR_BASE_ADDRESS) |=> CFG_RDATA[10:0] == 11'h000)
        else $error("base low bits not zero");
    a_cap_pointer: assert property (s_read_req(`OFS_CAPABILITY_POINTER) |=>
        CFG_RDATA == (NEW_CAP_FLAG ? 32'h0000_0050 : 32'h0000_0000)) else $error("pointer wrong");
    a_wake_drive: assert property (PM_EVENT && keep.wake_enable |=> !WAKE_OUT_N_OE_N)
        else $error("wake pin not driven");
    a_wake_clear: assert property (wr && byte_addr == `OFS_PM_CONTROL_STATUS && !CFG_CMD.byte_en_n[1]
        && CFG_CMD.wdata[15] && !PM_EVENT |=> WAKE_OUT_N_OE_N) else $error("wake not released");
    a_soft_reset: assert property (s_d3_to_d0 |=> SOFT_RESET_OUT == !NO_SOFT_RESET && POWER_STATE == 2'h0)
        else $error("d3 to d0 reset wrong");
    a_lat_drop: assert property ($rose(FRAME_OUT_N) |=> !cur.lat_exp && !LAT_TERMINATE)
        else $error("latency count kept");
    a_mirror: assert property (PM_CAP_MIRROR[14] && !PM_CAP_MIRROR[11] && PM_CAP_MIRROR[8:6] == 3'h0)
        else $error("capability mirror wrong");

endmodule // pci_config_space_pm

// File: tb/pci_host_model.sv
/*
 * behavioural host bridge issuing configuration cycles.
 * assumes a one-cycle request answered by a done or retry pulse.
 */
`timescale 1ns/100ps
module pci_host_model
    import pci_cfg_pm_pkg::*;
(
    input wire logic CORE_CLK, // core clock
    output logic CFG_REQ, // request pulse
    output cfg_req_t CFG_CMD, // request fields
    input wire logic CFG_DONE, // normal completion
    input wire logic CFG_RETRY, // retry termination
    input wire logic [31:0] CFG_RDATA // read data
);
    // ****************************************
    // idle bus
    // ****************************************
    initial begin
        CFG_REQ = 1'b0;
        CFG_CMD = '0;
    end

    // one cycle, launched on a falling edge; no data unless completed
    task automatic access(input logic wr, input logic [7:0] ofs, input logic [3:0] be_n,
            input logic [31:0] wd, output logic [31:0] rd, output logic retry);
        int n;
        n = 0;
        @(negedge CORE_CLK);
        CFG_REQ <= 1'b1;
        CFG_CMD <= '{write: wr, dword_idx: ofs[7:2], byte_en_n: be_n, wdata: wd};
        @(negedge CORE_CLK);
        CFG_REQ <= 1'b0;
        CFG_CMD <= ~CFG_CMD; // released fields stop showing the request
        while (CFG_DONE !== 1'b1 && CFG_RETRY !== 1'b1 && n < 4) begin
            @(negedge CORE_CLK);
            n++;
        end
        rd = (CFG_DONE === 1'b1) ? CFG_RDATA : 'x;
        retry = (CFG_RETRY === 1'b1);
    endtask
endmodule // pci_host_model

// File: tb/test_pci_config_space_pm.sv
/*
 * self-checking bench for the configuration-space bank.
 * assumes the host model and a 40 MHz core clock.
 */
`timescale 1ns/100ps
`include "pci_cfg_pm_defines.svh"
module test_pci_config_space_pm;
    import pci_cfg_pm_pkg::*;
    localparam int LOAD_CYC = 20;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic POWER_UP_RESET_N = 1'b0;
    logic [31:0] EE_SUBSYS = 32'h5A3C_0F96; // arbitrary identity value
    ee_cfg_t EE_CFG = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h2};
    logic EE_VALID = 1'b1, FRAME_OUT_N = 1'b1, GNT_N = 1'b0, PM_EVENT = 1'b0;
    logic CFG_REQ, CFG_DONE, CFG_RETRY, LAT_TERMINATE, WAKE_OUT_N_O, WAKE_OUT_N_OE_N;
    logic NEW_CAP_FLAG, LOAD_DONE, SOFT_RESET_OUT, retry;
    cfg_req_t CFG_CMD;
    logic [31:0] CFG_RDATA, CSR_BASE_ADDR, rd;
    logic [15:0] PM_CAP_MIRROR;
    logic [1:0] POWER_STATE;
    int miscompares = 0, comparisons = 0, cycles = 0, soft_pulses = 0, rel = 0;

    pci_config_space_pm #(.EE_LOAD_CYCLES(LOAD_CYC)) dut_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
        .POWER_UP_RESET_N(POWER_UP_RESET_N), .CFG_REQ(CFG_REQ), .CFG_CMD(CFG_CMD), .CFG_DONE(CFG_DONE),
        .CFG_RETRY(CFG_RETRY), .CFG_RDATA(CFG_RDATA), .EE_SUBSYS(EE_SUBSYS), .EE_CFG(EE_CFG),
        .EE_VALID(EE_VALID), .FRAME_OUT_N(FRAME_OUT_N), .GNT_N(GNT_N), .LAT_TERMINATE(LAT_TERMINATE),
        .PM_EVENT(PM_EVENT), .WAKE_OUT_N_O(WAKE_OUT_N_O), .WAKE_OUT_N_OE_N(WAKE_OUT_N_OE_N),
        .NEW_CAP_FLAG(NEW_CAP_FLAG), .PM_CAP_MIRROR(PM_CAP_MIRROR), .CSR_BASE_ADDR(CSR_BASE_ADDR),
        .POWER_STATE(POWER_STATE), .LOAD_DONE(LOAD_DONE), .SOFT_RESET_OUT(SOFT_RESET_OUT));
    pci_host_model host_u (.CORE_CLK(CORE_CLK), .CFG_REQ(CFG_REQ), .CFG_CMD(CFG_CMD),
        .CFG_DONE(CFG_DONE), .CFG_RETRY(CFG_RETRY), .CFG_RDATA(CFG_RDATA));

    // ****************************************
    // clock, cycle ceiling, pulse count
    // ****************************************
    always #12.5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cycles++;
        if (SOFT_RESET_OUT === 1'b1) soft_pulses++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] pm_cap(input ee_cfg_t e);
        return {e.wake_d3cold, 1'b1, e.wake_d2, e.wake_d1, 1'b0, e.state2_support, e.state1_support,
            3'h0, e.special_init, 1'b0, e.wake_clock, e.pm_version, 8'h00, 8'h01};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        host_u.access(1'b0, ofs, 4'h0, 32'h0000_0000, rd, retry);
        check(rd, exp);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be_n, input logic [31:0] d);
        host_u.access(1'b1, ofs, be_n, d, rd, retry);
    endtask
    task automatic wait_load();
        for (int i = 0; i < 200 && LOAD_DONE !== 1'b1; i++) @(negedge CORE_CLK);
        check({31'h0, LOAD_DONE}, 32'h1);
    endtask
    task automatic pulse_event();
        PM_EVENT = 1'b1;
        @(negedge CORE_CLK);
        PM_EVENT = 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge CORE_CLK);
        RESET_N = 1'b1;
        POWER_UP_RESET_N = 1'b1;
        rel = cycles;
        host_u.access(1'b0, `OFS_SUBSYSTEM_IDENTITY, 4'h0, 32'h0000_0000, rd, retry);
        check({31'h0, retry}, 32'h1);
        rd_chk(`OFS_INTERRUPT_ROUTING, 32'h2814_0100);
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_0000);
        wr(`OFS_CLASS_REVISION, 4'h0, 32'hFFFF_FFFF);
        rd_chk(`OFS_CLASS_REVISION, 32'h0200_0010);
        wr(`OFS_LATENCY_CACHE_LINE, 4'h0, 32'hFFFF_FFFF);
        rd_chk(`OFS_LATENCY_CACHE_LINE, 32'h0000_FFFF);
        wr(`OFS_CSR_BASE_ADDRESS, 4'h0, 32'hFFFF_FFFF);
        rd_chk(`OFS_CSR_BASE_ADDRESS, 32'hFFFF_F800);
        wr(`OFS_CSR_BASE_ADDRESS, 4'h7, 32'h1234_5678);
        check(CSR_BASE_ADDR, 32'h12FF_F800);
        wr(`OFS_INTERRUPT_ROUTING, 4'hE, 32'h0000_00A5);
        rd_chk(`OFS_INTERRUPT_ROUTING, 32'h2814_01A5);
        wr(8'h14, 4'h0, 32'hFFFF_FFFF);
        rd_chk(8'h14, 32'h0000_0000);
        while (cycles - rel < 60) @(negedge CORE_CLK);
        check({31'h0, LOAD_DONE}, 32'h0);
        wait_load();
        wr(`OFS_SUBSYSTEM_IDENTITY, 4'h0, 32'h0000_0000);
        rd_chk(`OFS_SUBSYSTEM_IDENTITY, EE_SUBSYS);
        rd_chk(`OFS_CAPABILITY_POINTER, 32'h0000_0050);
        check({31'h0, NEW_CAP_FLAG}, 32'h1);
        wr(`OFS_PM_CAPABILITY, 4'h0, 32'h0000_0000);
        rd_chk(`OFS_PM_CAPABILITY, pm_cap(EE_CFG));
        check({16'h0, PM_CAP_MIRROR}, pm_cap(EE_CFG) >> 16);
        $display("test registers done");
        // power states, then D3-hot to D0 with the internal reset
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_PM_CONTROL_STATUS, 4'hE, 32'(s));
            rd_chk(`OFS_PM_CONTROL_STATUS, 32'(s));
        end
        wr(`OFS_PM_CONTROL_STATUS, 4'hE, 32'h0000_0008);
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_0000);
        check(32'(soft_pulses), 32'h1);
        rd_chk(`OFS_LATENCY_CACHE_LINE, 32'h0000_FFFF);
        $display("test power states done");
        // latency count against a timer of four
        wr(`OFS_LATENCY_CACHE_LINE, 4'hC, 32'h0000_0400);
        FRAME_OUT_N = 1'b0;
        repeat (8) @(negedge CORE_CLK);
        check({31'h0, LAT_TERMINATE}, 32'h0);
        GNT_N = 1'b1;
        repeat (5) @(negedge CORE_CLK);
        check({31'h0, LAT_TERMINATE}, 32'h1);
        FRAME_OUT_N = 1'b1;
        repeat (3) @(negedge CORE_CLK);
        FRAME_OUT_N = 1'b0;
        repeat (3) @(negedge CORE_CLK);
        FRAME_OUT_N = 1'b1;
        @(negedge CORE_CLK);
        check({31'h0, LAT_TERMINATE}, 32'h0);
        FRAME_OUT_N = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        check({31'h0, LAT_TERMINATE}, 32'h0);
        repeat (4) @(negedge CORE_CLK);
        check({31'h0, LAT_TERMINATE}, 32'h1);
        FRAME_OUT_N = 1'b1;
        $display("test latency done");
        // wake event, hardware reset, clears
        wr(`OFS_PM_CONTROL_STATUS, 4'hD, 32'h0000_0100);
        pulse_event();
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_8100);
        check({30'h0, WAKE_OUT_N_O, WAKE_OUT_N_OE_N}, 32'h0);
        RESET_N = 1'b0;
        EE_CFG = '0;
        @(negedge CORE_CLK);
        RESET_N = 1'b1;
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_8100);
        rd_chk(`OFS_CSR_BASE_ADDRESS, 32'h0000_0000);
        wait_load();
        rd_chk(`OFS_CAPABILITY_POINTER, 32'h0000_0000);
        check({31'h0, NEW_CAP_FLAG}, 32'h0);
        rd_chk(`OFS_PM_CAPABILITY, 32'h4000_0001);
        wr(`OFS_PM_CONTROL_STATUS, 4'hD, 32'h0000_8100);
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_0100);
        check({31'h0, WAKE_OUT_N_OE_N}, 32'h1);
        wr(`OFS_PM_CONTROL_STATUS, 4'hD, 32'h0000_0000);
        pulse_event();
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_8000);
        check({31'h0, WAKE_OUT_N_OE_N}, 32'h1);
        POWER_UP_RESET_N = 1'b0;
        RESET_N = 1'b0;
        @(negedge CORE_CLK);
        POWER_UP_RESET_N = 1'b1;
        RESET_N = 1'b1;
        rd_chk(`OFS_PM_CONTROL_STATUS, 32'h0000_0000);
        $display("test wake done");
        give_verdict();
    end
endmodule // test_pci_config_space_pm
